/* File: rtl/gshi_pkg.sv */
package gshi_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  // serial link rates, divisors round down
  localparam int BAUD_DEF = 38400;
  localparam int BAUD_LOW = 9600;
  localparam int BAUD_MID = 19200;
  localparam int DIV_DEF = SEC_NS / (CLK_PERIOD_NS * BAUD_DEF);
  localparam int DIV_LOW = SEC_NS / (CLK_PERIOD_NS * BAUD_LOW);
  localparam int DIV_MID = SEC_NS / (CLK_PERIOD_NS * BAUD_MID);
  localparam logic [1:0] BAUD_SEL_DEF = 2'h0;
  localparam logic [1:0] BAUD_SEL_LOW = 2'h1;
  localparam logic [1:0] BAUD_SEL_MID = 2'h2;
  // measurement timing in seconds, manual hold in minutes, auto periods in days
  localparam int SAMPLE_S = 3;
  localparam int WARMUP_S = 6;
  localparam int MANUAL_HOLD_MIN = 1;
  localparam int MANUAL_HOLD_S = MANUAL_HOLD_MIN * 60;
  localparam int DAY_S = 86400;
  localparam int AUTO_FIRST_DAYS = 2;
  localparam int AUTO_SECOND_DAYS = 5;
  localparam int AUTO_PERIOD_DAYS = 7;
  // scale
  localparam int FULL_SCALE_PPM = 5000;
  localparam int PPM_PER_PCT = 500;
  // two-wire slave
  localparam logic [6:0] I2C_ADDR = 7'h31;
  localparam logic [7:0] I2C_READ_REQ = 8'h52;
  localparam logic [2:0] RESP_LAST = 3'h6;
  // command characters, on either link
  localparam logic [7:0] CMD_MANUAL = 8'h4d;
  localparam logic [7:0] CMD_AUTO_ON = 8'h41;
  localparam logic [7:0] CMD_AUTO_OFF = 8'h4e;
  localparam logic [7:0] CMD_BAUD_LOW = 8'h31;
  localparam logic [7:0] CMD_BAUD_MID = 8'h32;
  localparam logic [7:0] CMD_BAUD_DEF = 8'h33;
  // frame characters
  localparam logic [7:0] ASC_SP = 8'h20;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_PCT = 8'h25;
  localparam logic [7:0] ASC_CR = 8'h0d;
  localparam logic [7:0] ASC_LF = 8'h0a;
  localparam logic [7:0] ASC_L = 8'h4c;
  localparam logic [7:0] ASC_E = 8'h45;
  localparam logic [7:0] ASC_P = 8'h70;
  localparam logic [7:0] ASC_M = 8'h6d;
  localparam logic [3:0] FRAME_LAST_PCT = 4'hb;
  localparam logic [3:0] FRAME_LAST_PPM = 4'ha;
  // transmit buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
endpackage : gshi_pkg

/* File: rtl/gshi_byte_if.sv */
`timescale 1ns/1ps
interface gshi_byte_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : gshi_byte_if

/* File: rtl/gshi_fifo.sv */
`timescale 1ns/1ps
module gshi_fifo
  import gshi_pkg::*;
#(
  parameter int W = FIFO_WIDTH,
  parameter int D = FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill and drain sides
  gshi_byte_if.snk put,
  gshi_byte_if.src get
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = put.valid && put.ready;
  wire pop = get.valid && get.ready;
  assign put.ready = count != (AW+1)'(D);
  assign get.valid = count != '0;
  assign get.data = mem[rd_ptr];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= put.data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wrap_inc(wr_ptr);
      if (pop)
        rd_ptr <= wrap_inc(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule : gshi_fifo

/* File: rtl/gshi_sensor_if.sv */
// Behaviour
// - serial link defaults to 38400 baud, 8 data bits, no parity, one stop
// - a command switches the serial rate to 9600 or 19200, format unchanged
// - two-wire port is slave only, never drives the clock line
// - answers slave address 0x31; first byte 0x63 reads, 0x62 writes
// - read returns config byte, two concentration bytes, four zero bytes
// - percent frame: three spaces, two digits, %, space, LEL, CR LF
// - leading zero digits in the number field are sent as spaces
// - ppm frame: right-aligned number, space, ppm, CR LF
// - a fresh sample is taken and reported every three seconds
// - no results before six seconds after power-up
// - ppm units by default over a 5000 ppm full scale
// - manual pin low one minute, or command, zeroes the sensor
// - auto calibration fires after 2 days, then 5, then weekly
// - pin decode: manual, automatic, or normal with stored calibration
// - calibration commands accepted over serial link or two-wire port
`timescale 1ns/1ps
module gshi_sensor_if
  import gshi_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES,
  parameter int FULL_SCALE = FULL_SCALE_PPM
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  input wire logic uart_rx,
  output logic uart_tx,
  // two-wire slave, clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // calibration pins, active low
  input wire logic manual_zero_cal_pin,
  input wire logic auto_zero_cal_pin,
  // measurement core
  input wire logic [15:0] conc_ppm,
  input wire logic explosive_limit_percent_unit,
  output logic sample_req,
  output logic result_valid,
  // calibration and status
  output logic zero_cal_pulse,
  output logic auto_cal_enabled,
  output logic [1:0] baud_code
);
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RACK} gshi_i2c_e;

  function automatic logic [13:0] baud_div(input logic [1:0] sel);
    return (sel == BAUD_SEL_LOW) ? 14'(DIV_LOW) :
           (sel == BAUD_SEL_MID) ? 14'(DIV_MID) : 14'(DIV_DEF);
  endfunction : baud_div

  function automatic logic [7:0] digit_char(input int val, input int pos);
    int p;
    p = 10 ** pos;
    if (pos != 0 && val < p)
      return ASC_SP;
    return ASC_ZERO + 8'((val / p) % 10);
  endfunction : digit_char

  function automatic logic [7:0] frame_char(input logic pct, input logic [3:0] i,
                                            input logic [15:0] v);
    int n;
    logic [7:0] c;
    n = pct ? int'(v) / PPM_PER_PCT : int'(v);
    if (n > 99 && pct)
      n = 99;
    c = ASC_SP;
    if (pct)
    begin
      case (i)
        4'h3: c = digit_char(n, 1);
        4'h4: c = digit_char(n, 0);
        4'h5: c = ASC_PCT;
        4'h7, 4'h9: c = ASC_L;
        4'h8: c = ASC_E;
        4'ha: c = ASC_CR;
        4'hb: c = ASC_LF;
        default: c = ASC_SP;
      endcase
    end
    else
    begin
      case (i)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4: c = digit_char(n, 4 - int'(i));
        4'h6, 4'h7: c = ASC_P;
        4'h8: c = ASC_M;
        4'h9: c = ASC_CR;
        4'ha: c = ASC_LF;
        default: c = ASC_SP;
      endcase
    end
    return c;
  endfunction : frame_char

  // reset release and pin synchronisers
  logic rst_s1;
  logic rst_n;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_d;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
      pin_d <= 5'h1f;
    end
    else
    begin
      pin_s1 <= {auto_zero_cal_pin, manual_zero_cal_pin, sda_in, scl_in, uart_rx};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  wire rx_s = pin_s2[0];
  wire scl_s = pin_s2[1];
  wire sda_s = pin_s2[2];
  wire man_s = pin_s2[3];
  wire auto_s = pin_s2[4];
  wire scl_rise = scl_s && !pin_d[1];
  wire scl_fall = !scl_s && pin_d[1];
  wire i2c_start = scl_s && pin_d[1] && pin_d[2] && !sda_s;
  wire i2c_stop = scl_s && pin_d[1] && !pin_d[2] && sda_s;

  // seconds time base, warm-up and sampling
  logic [26:0] sec_cnt;
  logic [2:0] up_s;
  logic [1:0] smp_s;
  logic [15:0] value;
  wire sec_tick = sec_cnt == 27'(SEC_CYCLES_P - 1);
  wire sample_tick = sec_tick && smp_s == 2'(SAMPLE_S - 1);
  wire warm_now = result_valid || (sec_tick && up_s == 3'(WARMUP_S - 1));
  wire [15:0] clamped = (conc_ppm > 16'(FULL_SCALE)) ? 16'(FULL_SCALE) : conc_ppm;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_cnt <= '0;
      up_s <= '0;
      smp_s <= '0;
      result_valid <= 1'b0;
      sample_req <= 1'b0;
      value <= '0;
    end
    else
    begin
      sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
      if (sec_tick && !result_valid)
        up_s <= up_s + 1'b1;
      if (sec_tick)
        smp_s <= sample_tick ? '0 : smp_s + 1'b1;
      result_valid <= warm_now;
      sample_req <= sample_tick;
      if (sample_tick)
        value <= clamped;
    end
  end

  // frame builder feeding the transmit buffer
  gshi_byte_if #(.W(FIFO_WIDTH)) frm_if();
  gshi_byte_if #(.W(FIFO_WIDTH)) tx_if();
  logic frm_busy;
  logic frm_pct;
  logic [3:0] frm_idx;
  wire [3:0] frm_last = frm_pct ? FRAME_LAST_PCT : FRAME_LAST_PPM;
  assign frm_if.data = frame_char(frm_pct, frm_idx, value);
  assign frm_if.valid = frm_busy;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frm_busy <= 1'b0;
      frm_pct <= 1'b0;
      frm_idx <= '0;
    end
    else if (!frm_busy)
    begin
      // a sample that lands while a frame drains is skipped, not queued
      if (sample_tick && warm_now)
      begin
        frm_busy <= 1'b1;
        frm_pct <= explosive_limit_percent_unit;
        frm_idx <= '0;
      end
    end
    else if (frm_if.ready)
    begin
      frm_idx <= frm_idx + 1'b1;
      if (frm_idx == frm_last)
        frm_busy <= 1'b0;
    end
  end

  gshi_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .put(frm_if),
    .get(tx_if)
  );

  // serial transmitter
  logic tx_busy;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic [13:0] tx_cnt;
  wire [13:0] div = baud_div(baud_code);
  assign tx_if.ready = !tx_busy;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_busy <= 1'b0;
      tx_sh <= 10'h3ff;
      tx_bits <= '0;
      tx_cnt <= '0;
      uart_tx <= 1'b1;
    end
    else
    begin
      uart_tx <= tx_busy ? tx_sh[0] : 1'b1;
      if (!tx_busy && tx_if.valid)
      begin
        tx_sh <= {1'b1, tx_if.data, 1'b0};
        tx_busy <= 1'b1;
        tx_bits <= '0;
        tx_cnt <= '0;
      end
      else if (tx_busy && tx_cnt >= div - 1'b1)
      begin
        tx_cnt <= '0;
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bits <= tx_bits + 1'b1;
        if (tx_bits == 4'h9)
          tx_busy <= 1'b0;
      end
      else if (tx_busy)
        tx_cnt <= tx_cnt + 1'b1;
    end
  end

  // serial receiver, commands only
  logic rx_busy;
  logic rx_done;
  logic [7:0] rx_sh;
  logic [3:0] rx_bits;
  logic [13:0] rx_cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_sh <= '0;
      rx_bits <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (!rx_busy)
      begin
        if (!rx_s)
        begin
          rx_busy <= 1'b1;
          rx_bits <= '0;
          rx_cnt <= div >> 1;
        end
      end
      else if (rx_cnt != '0)
        rx_cnt <= rx_cnt - 1'b1;
      else
      begin
        rx_cnt <= div - 1'b1;
        rx_bits <= rx_bits + 1'b1;
        // a start bit gone high by mid-bit was a glitch
        if (rx_bits == 4'h0 && rx_s)
          rx_busy <= 1'b0;
        else if (rx_bits == 4'h9)
        begin
          rx_busy <= 1'b0;
          rx_done <= rx_s;
        end
        else if (rx_bits != 4'h0)
          rx_sh <= {rx_s, rx_sh[7:1]};
      end
    end
  end

  // two-wire slave
  gshi_i2c_e i_st;
  logic [3:0] i_bits;
  logic [7:0] i_sh;
  logic i_rd;
  logic [2:0] i_idx;
  logic i_wr;
  logic [15:0] snap;
  wire [7:0] cfg_byte = {3'h0, baud_code, result_valid, auto_cal_enabled, frm_pct};
  wire [7:0] resp_byte = (i_idx == 3'h0) ? cfg_byte :
                         (i_idx == 3'h1) ? snap[15:8] :
                         (i_idx == 3'h2) ? snap[7:0] : 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i_st <= I_IDLE;
      i_bits <= '0;
      i_sh <= '0;
      i_rd <= 1'b0;
      i_idx <= '0;
      i_wr <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      i_wr <= 1'b0;
      sda_out <= 1'b0;
      if (i2c_start)
      begin
        i_st <= I_ADDR;
        i_bits <= '0;
        sda_oe <= 1'b0;
      end
      else if (i2c_stop)
      begin
        i_st <= I_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (i_st)
          I_IDLE: ;
          I_ADDR, I_WR:
            if (scl_rise && i_bits != 4'h8)
            begin
              i_sh <= {i_sh[6:0], sda_s};
              i_bits <= i_bits + 1'b1;
            end
            else if (scl_fall && i_bits == 4'h8)
            begin
              if (i_st == I_WR)
              begin
                sda_oe <= 1'b1;
                i_wr <= 1'b1;
                i_st <= I_ACK;
              end
              else if (i_sh[7:1] == I2C_ADDR)
              begin
                sda_oe <= 1'b1;
                i_rd <= i_sh[0];
                i_idx <= '0;
                i_st <= I_ACK;
              end
              else
                i_st <= I_IDLE;
            end
          I_ACK:
            if (scl_fall)
            begin
              i_bits <= '0;
              if (i_rd)
              begin
                i_sh <= resp_byte;
                sda_oe <= !resp_byte[7];
                i_idx <= (i_idx == RESP_LAST) ? i_idx : i_idx + 1'b1;
                i_st <= I_RD;
              end
              else
              begin
                sda_oe <= 1'b0;
                i_st <= I_WR;
              end
            end
          I_RD:
            if (scl_fall)
            begin
              i_bits <= i_bits + 1'b1;
              if (i_bits == 4'h7)
              begin
                sda_oe <= 1'b0;
                i_st <= I_RACK;
              end
              else
              begin
                i_sh <= {i_sh[6:0], 1'b0};
                sda_oe <= !i_sh[6];
              end
            end
          I_RACK:
            if (scl_rise)
              i_st <= sda_s ? I_IDLE : I_ACK;
        endcase
      end
    end
  end

  // commands from both links
  wire cmd_is_rx_manual = rx_done && rx_sh == CMD_MANUAL;
  wire cmd_is_i2c_manual = i_wr && i_sh == CMD_MANUAL;
  wire cmd_manual = cmd_is_rx_manual || cmd_is_i2c_manual;
  wire cmd_auto_on = (rx_done && rx_sh == CMD_AUTO_ON) || (i_wr && i_sh == CMD_AUTO_ON);
  wire cmd_auto_off = (rx_done && rx_sh == CMD_AUTO_OFF) || (i_wr && i_sh == CMD_AUTO_OFF);
  wire read_req = i_wr && i_sh == I2C_READ_REQ;

  // calibration pin decode, both low falls back to normal
  wire mode_manual = !man_s && auto_s;
  wire mode_auto = man_s && !auto_s;
  logic auto_cmd;
  logic man_held;
  logic [5:0] man_sec;
  logic [19:0] auto_sec;
  logic [1:0] auto_stage;
  wire auto_on = mode_auto || auto_cmd;
  wire [19:0] auto_target = (auto_stage == 2'h0) ? 20'(AUTO_FIRST_DAYS * DAY_S) :
                            (auto_stage == 2'h1) ? 20'(AUTO_SECOND_DAYS * DAY_S) :
                            20'(AUTO_PERIOD_DAYS * DAY_S);
  wire man_fire = mode_manual && !man_held && sec_tick &&
                  man_sec == 6'(MANUAL_HOLD_S);
  wire auto_fire = auto_on && sec_tick && auto_sec == auto_target - 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auto_cmd <= 1'b0;
      man_held <= 1'b0;
      man_sec <= '0;
      auto_sec <= '0;
      auto_stage <= '0;
      zero_cal_pulse <= 1'b0;
      auto_cal_enabled <= 1'b0;
      baud_code <= BAUD_SEL_DEF;
      snap <= '0;
    end
    else
    begin
      zero_cal_pulse <= man_fire || cmd_manual || auto_fire;
      auto_cal_enabled <= auto_on;
      if (cmd_auto_on)
        auto_cmd <= 1'b1;
      else if (cmd_auto_off)
        auto_cmd <= 1'b0;
      // one firing per hold; the pin must rise before another
      if (!mode_manual)
      begin
        man_sec <= '0;
        man_held <= 1'b0;
      end
      else if (man_fire)
        man_held <= 1'b1;
      else if (sec_tick && !man_held)
        man_sec <= man_sec + 1'b1;
      if (!auto_on)
      begin
        auto_sec <= '0;
        auto_stage <= '0;
      end
      else if (auto_fire)
      begin
        auto_sec <= '0;
        auto_stage <= (auto_stage == 2'h2) ? auto_stage : auto_stage + 1'b1;
      end
      else if (sec_tick)
        auto_sec <= auto_sec + 1'b1;
      if ((rx_done && rx_sh == CMD_BAUD_LOW) || (i_wr && i_sh == CMD_BAUD_LOW))
        baud_code <= BAUD_SEL_LOW;
      else if ((rx_done && rx_sh == CMD_BAUD_MID) || (i_wr && i_sh == CMD_BAUD_MID))
        baud_code <= BAUD_SEL_MID;
      else if ((rx_done && rx_sh == CMD_BAUD_DEF) || (i_wr && i_sh == CMD_BAUD_DEF))
        baud_code <= BAUD_SEL_DEF;
      if (read_req)
        snap <= value;
    end
  end
endmodule : gshi_sensor_if

/* File: tb/gshi_sensor_if_chk.sv */
`timescale 1ns/1ps
module gshi_sensor_if_chk #(
  parameter int SEC_CYCLES_P = 100,
  parameter int FULL_SCALE = 5000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial and two-wire pins
  input wire logic uart_rx,
  input wire logic uart_tx,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // calibration pins
  input wire logic manual_zero_cal_pin,
  input wire logic auto_zero_cal_pin,
  // core and status
  input wire logic [15:0] conc_ppm,
  input wire logic explosive_limit_percent_unit,
  input wire logic sample_req,
  input wire logic result_valid,
  input wire logic zero_cal_pulse,
  input wire logic auto_cal_enabled,
  input wire logic [1:0] baud_code
);
  int up;
  int gap;
  int hold;
  logic seen;
  logic man_zc;
  // counts start at the raw pin edges, so windows allow for the sync flops
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      up <= 0;
      gap <= 0;
      hold <= 0;
      seen <= 1'b0;
      man_zc <= 1'b0;
    end
    else
    begin
      up <= up + 1;
      gap <= sample_req ? 0 : gap + 1;
      seen <= seen | sample_req;
      hold <= (!manual_zero_cal_pin && auto_zero_cal_pin) ? hold + 1 : 0;
      man_zc <= (hold != 0) && (man_zc || zero_cal_pulse);
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_warm_not_early: assert property (up < 6 * SEC_CYCLES_P |-> !result_valid)
    else $error("result valid before warm-up");
  a_warm_on_time: assert property (up == 6 * SEC_CYCLES_P + 8 |-> result_valid)
    else $error("result valid late");
  a_result_held: assert property (result_valid |=> result_valid)
    else $error("result valid dropped");
  a_sample_period: assert property (sample_req && seen |-> gap == 3 * SEC_CYCLES_P - 1)
    else $error("sample spacing wrong");
  a_sample_not_late: assert property (seen |-> gap < 3 * SEC_CYCLES_P)
    else $error("sample overdue");
  a_sda_low_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed while clock high");
  a_manual_hold: assert property (hold == 61 * SEC_CYCLES_P + 4 |-> man_zc)
    else $error("no zeroing after manual hold");
  a_auto_pin_arms: assert property
    ((!auto_zero_cal_pin && manual_zero_cal_pin) [*8] |-> auto_cal_enabled)
    else $error("auto pin not decoded");
  a_reset_quiet: assert property (disable iff (1'b0)
    (!resetn) [*2] |-> uart_tx && !sda_oe && !result_valid && baud_code == 2'h0)
    else $error("outputs active in reset");
  a_baud_legal: assert property (baud_code != 2'h3)
    else $error("illegal rate code");
  c_zeroing: cover property (zero_cal_pulse);
  c_slave_drive: cover property (sda_oe && scl_in);
  c_low_rate: cover property (baud_code == 2'h1);
endmodule : gshi_sensor_if_chk

bind gshi_sensor_if gshi_sensor_if_chk #(.SEC_CYCLES_P(SEC_CYCLES_P), .FULL_SCALE(FULL_SCALE))
  u_chk (.clk(clk), .resetn(resetn), .uart_rx(uart_rx), .uart_tx(uart_tx), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .manual_zero_cal_pin(manual_zero_cal_pin), .auto_zero_cal_pin(auto_zero_cal_pin),
  .conc_ppm(conc_ppm), .explosive_limit_percent_unit(explosive_limit_percent_unit),
  .sample_req(sample_req), .result_valid(result_valid), .zero_cal_pulse(zero_cal_pulse),
  .auto_cal_enabled(auto_cal_enabled), .baud_code(baud_code));

/* File: tb/gshi_host.sv */
`timescale 1ns/1ps
module gshi_host
  import gshi_pkg::*;
#(
  parameter int H = 10
)
(
  // clock
  input wire logic clk,
  // serial link
  input wire logic uart_tx,
  output logic uart_rx,
  // two-wire bus
  output logic scl,
  output logic sda_w,
  input wire logic sda_oe,
  input wire logic sda_out
);
  logic sda_lo = 1'b0;
  logic en = 1'b0;
  logic [7:0] rxq[$];
  // pull-up wins unless a party pulls low
  assign sda_w = !(sda_lo || (sda_oe && !sda_out));
  initial
  begin
    uart_rx = 1'b1;
    scl = 1'b1;
  end
  // 8n1 receiver, mid-bit sampling at the default rate only
  initial
    forever
    begin : mon
      logic [7:0] b;
      @(negedge uart_tx iff en);
      repeat (DIV_DEF / 2) @(posedge clk);
      repeat (8)
      begin
        repeat (DIV_DEF) @(posedge clk);
        b = {uart_tx, b[7:1]};
      end
      repeat (DIV_DEF) @(posedge clk);
      if (uart_tx)
        rxq.push_back(b);
    end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      uart_rx = f[i];
      wait_n(DIV_DEF);
    end
  endtask : send
  task automatic bitx(input logic v, output logic r);
    sda_lo = !v;
    wait_n(H);
    scl = 1'b1;
    wait_n(H);
    r = sda_w;
    scl = 1'b0;
    wait_n(4);
  endtask : bitx
  task automatic start();
    sda_lo = 1'b0;
    wait_n(4);
    scl = 1'b1;
    wait_n(H);
    sda_lo = 1'b1;
    wait_n(H);
    scl = 1'b0;
    wait_n(4);
  endtask : start
  task automatic stop();
    sda_lo = 1'b1;
    wait_n(4);
    scl = 1'b1;
    wait_n(H);
    sda_lo = 1'b0;
    wait_n(H);
  endtask : stop
  // ack low means taken; the long bit time covers the per-byte pause
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
    output logic ao);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ai, ao);
  endtask : xfer
  task automatic read7(output logic [7:0] r[7], output logic [2:0] a);
    logic [7:0] q;
    start();
    xfer(8'h62, 1'b1, q, a[0]);
    xfer(8'h52, 1'b1, q, a[1]);
    stop();
    start();
    xfer(8'h63, 1'b1, q, a[2]);
    for (int i = 0; i < 7; i++)
      xfer(8'hff, i == 6, r[i], q[0]);
    stop();
  endtask : read7
endmodule : gshi_host

/* File: tb/tb_gshi_sensor_if.sv */
`timescale 1ns/1ps
module tb_gshi_sensor_if;
  import gshi_pkg::*;
  localparam int SEC = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic manual_zero_cal_pin = 1'b1;
  logic auto_zero_cal_pin = 1'b1;
  logic unit = 1'b0;
  logic [15:0] conc_ppm = 16'h0000;
  logic uart_rx, uart_tx, scl_in, sda_in, sda_out, sda_oe;
  logic sample_req, result_valid, zero_cal_pulse, auto_cal_enabled;
  logic [1:0] baud_code;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int zc = 0;
  gshi_sensor_if #(.SEC_CYCLES_P(SEC)) dut (.clk(clk), .resetn(resetn), .uart_rx(uart_rx),
    .uart_tx(uart_tx), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .manual_zero_cal_pin(manual_zero_cal_pin), .auto_zero_cal_pin(auto_zero_cal_pin),
    .conc_ppm(conc_ppm), .explosive_limit_percent_unit(unit), .sample_req(sample_req),
    .result_valid(result_valid), .zero_cal_pulse(zero_cal_pulse),
    .auto_cal_enabled(auto_cal_enabled), .baud_code(baud_code));
  gshi_host host (.clk(clk), .uart_tx(uart_tx), .uart_rx(uart_rx), .scl(scl_in),
    .sda_w(sda_in), .sda_oe(sda_oe), .sda_out(sda_out));
  initial
    forever
      #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (zero_cal_pulse === 1'b1)
      zc++;
    if (cyc == 90000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_v
  task automatic wr_cmd(input logic [7:0] c, output logic [1:0] a);
    logic [7:0] q;
    host.start();
    host.xfer(8'h62, 1'b1, q, a[0]);
    host.xfer(c, 1'b1, q, a[1]);
    host.stop();
  endtask : wr_cmd
  task automatic t_restart();
    @(negedge clk);
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    chk_v("defaults", 16'h0020, 16'({uart_tx, sda_oe, result_valid, auto_cal_enabled,
      baud_code}));
    $display("test restart done");
  endtask : t_restart
  task automatic t_warm();
    int n = 0;
    while (result_valid !== 1'b1 && n < 10 * SEC)
    begin
      @(negedge clk);
      n++;
    end
    chk_v("warm-up", 16'h0001, 16'(n >= 6 * SEC - 8 && n <= 6 * SEC + 3));
    $display("test warm-up done");
  endtask : t_warm
  task automatic t_read(input logic [15:0] v, input logic [15:0] e);
    logic [7:0] r[7];
    logic [2:0] a;
    conc_ppm = v;
    repeat (2) @(posedge clk iff sample_req === 1'b1);
    @(negedge clk);
    host.read7(r, a);
    chk_v("acks", 16'h0000, 16'(a));
    chk_v("config", 16'h0004, 16'(r[0]));
    chk_v("value", e, {r[1], r[2]});
    for (int i = 3; i < 7; i++)
      chk_v("reserved", 16'h0000, 16'(r[i]));
    $display("test read %h done", v);
  endtask : t_read
  task automatic t_bad_addr();
    logic [7:0] q;
    logic a;
    host.start();
    host.xfer(8'h64, 1'b1, q, a);
    host.stop();
    chk_v("foreign ack", 16'h0001, 16'(a));
    $display("test foreign address done");
  endtask : t_bad_addr
  task automatic t_cmds();
    logic [7:0] c[5] = '{CMD_BAUD_LOW, CMD_BAUD_MID, CMD_AUTO_ON, CMD_AUTO_OFF, CMD_BAUD_DEF};
    logic [2:0] e[5] = '{3'h1, 3'h2, 3'h6, 3'h2, 3'h0};
    logic [1:0] a;
    for (int i = 0; i < 5; i++)
    begin
      wr_cmd(c[i], a);
      chk_v("cmd acks", 16'h0000, 16'(a));
      chk_v("cmd effect", 16'(e[i]), 16'({auto_cal_enabled, baud_code}));
    end
    $display("test commands done");
  endtask : t_cmds
  task automatic t_pins();
    int n0;
    auto_zero_cal_pin = 1'b0;
    repeat (10) @(negedge clk);
    chk_v("auto pin", 16'h0001, 16'(auto_cal_enabled));
    auto_zero_cal_pin = 1'b1;
    n0 = zc;
    manual_zero_cal_pin = 1'b0;
    repeat (61 * SEC + 20) @(negedge clk);
    chk_v("manual hold", 16'h0001, 16'(zc - n0));
    // both low is illegal host use; must not zero
    n0 = zc;
    auto_zero_cal_pin = 1'b0;
    repeat (60 * SEC + 20) @(negedge clk);
    chk_v("both low", 16'h0000, 16'(zc - n0));
    manual_zero_cal_pin = 1'b1;
    auto_zero_cal_pin = 1'b1;
    $display("test pins done");
  endtask : t_pins
  task automatic t_frame();
    logic [1:0] a;
    int n0;
    int n = 0;
    wr_cmd(CMD_BAUD_MID, a);
    wr_cmd(CMD_AUTO_ON, a);
    conc_ppm = 16'd3500;
    t_restart();
    host.en = 1'b1;
    n0 = zc;
    fork
      host.send(CMD_MANUAL);
    join_none
    while (host.rxq.size() < 2 && n < 60000)
    begin
      @(negedge clk);
      n++;
    end
    chk_v("serial zeroing", 16'h0001, 16'(zc - n0));
    chk_v("frame byte 0", 16'(ASC_SP), 16'(host.rxq[0]));
    chk_v("frame byte 1", 16'h0033, 16'(host.rxq[1]));
    $display("test frame done");
  endtask : t_frame
  initial
  begin
    t_restart();
    t_warm();
    t_read(16'd1234, 16'h04d2);
    t_read(16'd6000, 16'h1388);
    t_bad_addr();
    t_cmds();
    t_pins();
    t_frame();
    print_verdict();
  end
endmodule : tb_gshi_sensor_if
